// ===== t16_cfg.svh
// constants for the 16-bit timer compare/counting block
`ifndef T16_CFG_SVH
`define T16_CFG_SVH

// register byte offsets
`define T16_OFF_CTRL    8'h00
`define T16_OFF_FORCE   8'h04
`define T16_OFF_COUNT   8'h08
`define T16_OFF_CMPA    8'h0C
`define T16_OFF_CMPB    8'h10
`define T16_OFF_CAPT    8'h14
`define T16_OFF_FLAGS   8'h18
`define T16_OFF_PORT    8'h1C

// control register fields
`define T16_CTRL_MODE_LSB  0
`define T16_CTRL_MODE_MSB  3
`define T16_CTRL_ACTA_LSB  4
`define T16_CTRL_ACTA_MSB  5
`define T16_CTRL_ACTB_LSB  6
`define T16_CTRL_ACTB_MSB  7
`define T16_CTRL_CS_LSB    8
`define T16_CTRL_CS_MSB    10
`define T16_CTRL_RESET     11'h000

// flag register bits
`define T16_FLAG_OVF   0
`define T16_FLAG_CMPA  1
`define T16_FLAG_CMPB  2
`define T16_FLAG_CAPT  3

// port register fields
`define T16_PORT_VAL_LSB  0
`define T16_PORT_DIR_LSB  2
`define T16_PORT_LAT_LSB  4

// waveform modes that are not PWM
`define T16_MODE_NORMAL     4'h0
`define T16_MODE_CLR_CMPA   4'h4
`define T16_MODE_CLR_CAPT   4'hC

// counter extremes
`define T16_CNT_MAX   16'hFFFF
`define T16_CNT_ZERO  16'h0000

// prescaler selects and division masks (divide minus one)
`define T16_CS_STOP   3'h0
`define T16_CS_DIV1   3'h1
`define T16_CS_DIV8   3'h2
`define T16_CS_DIV64  3'h3
`define T16_CS_DIV256 3'h4
`define T16_CS_DIV1K  3'h5
`define T16_DIV8_M    10'h007
`define T16_DIV64_M   10'h03F
`define T16_DIV256_M  10'h0FF
`define T16_DIV1K_M   10'h3FF

// output action codes
`define T16_ACT_NONE    2'h0
`define T16_ACT_TOGGLE  2'h1
`define T16_ACT_CLEAR   2'h2
`define T16_ACT_SET     2'h3

`endif

// ===== t16_chk.sv
// concurrent checks on the timer block ports
`timescale 1ns/1ns
`default_nettype none
`include "t16_cfg.svh"
module t16_chk
   import t16_pkg::*;
#(
   parameter int NUM_CH = 2
)(
   input wire logic              clk,
   input wire logic              sys_rst,
   input wire logic              wb_cyc_i,
   input wire logic              wb_stb_i,
   input wire logic              wb_we_i,
   input wire logic [7:0]        wb_adr_i,
   input wire logic [3:0]        wb_sel_i,
   input wire logic [31:0]       wb_dat_i,
   input wire logic [31:0]       wb_dat_o,
   input wire logic              wb_ack_o,
   input wire logic              capture_event,
   input wire logic [NUM_CH-1:0] pin_o,
   input wire logic [NUM_CH-1:0] pin_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // full-word write decode
   wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr  = req & wb_we_i & (wb_sel_i == 4'hF);
   wire pwr = wr & (wb_adr_i == `T16_OFF_PORT);
   wire cwr = wr & (wb_adr_i == `T16_OFF_CTRL);
   logic [1:0] act_a;
   logic [3:0] prt;
   logic [1:0] quiet;
   // cycles since the last write, saturating
   always_ff @(posedge clk)
      if (sys_rst | wr) quiet <= 2'h0;
      else if (quiet != 2'h3) quiet <= quiet + 2'h1;
   // shadow of action A and the port fields
   always_ff @(posedge clk)
      if (sys_rst) act_a <= 2'h0;
      else if (cwr) act_a <= wb_dat_i[5:4];
   always_ff @(posedge clk)
      if (sys_rst) prt <= 4'h0;
      else if (pwr) prt <= wb_dat_i[3:0];
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ans;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   property p_ack;
      s_req |=> s_ans;
   endproperty
   a_ack: assert property (p_ack) else $error("ack not a single pulse");
   property p_idle;
      !wb_ack_o |-> wb_dat_o == 32'h0;
   endproperty
   a_idle: assert property (p_idle) else $error("read data without ack");
   property p_upper;
      wb_ack_o |-> wb_dat_o[31:16] == 16'h0;
   endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   property p_force_rd;
      s_req ##0 (!wb_we_i && wb_adr_i == `T16_OFF_FORCE) |=> wb_dat_o == 0;
   endproperty
   a_force_rd: assert property (p_force_rd) else $error("force reads back");
   property p_rst_pins;
      $fell(sys_rst) |-> pin_o == '0 && pin_oe == '0;
   endproperty
   a_rst_pins: assert property (p_rst_pins)
      else $error("pins not cleared by reset");
   property p_oe_dir;
      pwr |-> ##2 pin_oe == $past(wb_dat_i[3:2], 2);
   endproperty
   a_oe_dir: assert property (p_oe_dir)
      else $error("pin enable differs from direction");
   property p_pin_port;
      quiet == 2'h3 && pin_oe[0] && act_a == 2'h0 |-> pin_o[0] == prt[0];
   endproperty
   a_pin_port: assert property (p_pin_port)
      else $error("pin not from port value");
   property p_rd_port;
      s_req ##0 (!wb_we_i && wb_adr_i == `T16_OFF_PORT)
         |=> wb_dat_o[3:0] == prt;
   endproperty
   a_rd_port: assert property (p_rd_port) else $error("port readback wrong");
endmodule : t16_chk
`default_nettype wire

// ===== t16_pkg.sv
// types shared by the 16-bit timer block
package t16_pkg;
   typedef logic [15:0] t16_count_t;
   typedef logic [1:0]  t16_action_t;
   typedef logic [3:0]  t16_mode_t;
endpackage : t16_pkg

// ===== t16_prescale.sv
// prescaler producing the timer clock tick from the i/o clock
`timescale 1ns/1ns
`default_nettype none
`include "t16_cfg.svh"
module t16_prescale
   import t16_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic [2:0] clk_sel,
   output logic            tick
);
   logic [9:0] pre_cnt;
   logic [9:0] div_mask;

   // division mask for the selected factor
   assign div_mask = (clk_sel == `T16_CS_DIV8)   ? `T16_DIV8_M   :
                     (clk_sel == `T16_CS_DIV64)  ? `T16_DIV64_M  :
                     (clk_sel == `T16_CS_DIV256) ? `T16_DIV256_M :
                     `T16_DIV1K_M;
   // one tick per N i/o clocks; stopped selects give none
   assign tick = (clk_sel == `T16_CS_DIV1) ? 1'b1 :
                 ((clk_sel == `T16_CS_STOP) || (clk_sel > `T16_CS_DIV1K))
                    ? 1'b0
                    : ((pre_cnt & div_mask) == div_mask);

   // free-running prescale counter
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pre_cnt <= 10'h000;
      end else begin
         pre_cnt <= pre_cnt + 10'h001;
      end
   end
endmodule : t16_prescale
`default_nettype wire

// ===== t16_timer.sv
// 16-bit timer: counter, compare outputs, flags and wishbone registers
`timescale 1ns/1ns
`default_nettype none
`include "t16_cfg.svh"
// Functional notes
// - reset clears every compare output latch to zero.
// - nonzero action field routes the latch to the pin, not port value.
// - pin direction bit still decides whether the pin drives.
// - action fields never touch the capture logic.
// - action code zero leaves the latch unchanged on a match.
// - a new action field applies from the next match onward.
// - force strobe applies the action at once in non-PWM modes.
// - counting depends only on mode select, never on action fields.
// - mode zero counts up always and wraps from FFFF to 0000.
// - overflow flag sets as count becomes zero; only software clears it.
// - counter may be written at any time in normal mode.
// - mode 4 tops at compare A, mode 12 at capture; clear on top.
// - reaching top sets compare A flag or capture flag.
// - top is unbuffered; below count means run on and wrap first.
// - toggle action on channel A gives a square wave in clear mode.
// - timer tick is i/o clock divided by 1, 8, 64, 256 or 1024.
// - in clear mode overflow sets only on the FFFF to 0000 roll.
// - continuous compare; match sets compare flag at the timer tick.
// - forced compare moves the latch only, no flag, no counter change.
// - counter write blocks matches in the next timer clock cycle.
module t16_timer
   import t16_pkg::*;
#(
   parameter int NUM_CH = 2
)(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        capture_event,
   output logic [NUM_CH-1:0] pin_o,
   output logic [NUM_CH-1:0] pin_oe
);
   logic [10:0]       ctrl;
   t16_count_t        counter_value;
   t16_count_t        compare_reg [NUM_CH];
   t16_count_t        capture_reg;
   logic [3:0]        flags;
   logic [NUM_CH-1:0] port_val;
   logic [NUM_CH-1:0] pin_direction_bit;
   logic [NUM_CH-1:0] compare_output_latch;
   logic              match_block;

   wire logic        tick;
   wire logic        bus_req;
   wire logic        bus_wr;
   wire logic        wr_ctrl;
   wire logic        wr_force;
   wire logic        wr_count;
   wire logic        wr_capt;
   wire logic        wr_flags;
   wire logic        wr_port;
   wire logic        lo_ok;
   wire t16_mode_t   waveform_mode_select;
   wire logic        non_pwm;
   wire logic        clear_on_match_mode;
   wire t16_count_t  top_value;
   wire logic        top_hit;
   wire logic        wrap_hit;
   wire logic        capt_allowed;
   wire logic [NUM_CH-1:0] ch_match;
   wire logic [NUM_CH-1:0] force_compare_strobe;
   wire t16_action_t output_action_field [NUM_CH];
   logic [31:0]      next_rdata;

   t16_prescale u_pre (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clk_sel (ctrl[`T16_CTRL_CS_MSB:`T16_CTRL_CS_LSB]),
      .tick    (tick)
   );

   // bus decode; a write is taken in the cycle ack is raised
   assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign bus_wr   = bus_req && wb_we_i;
   assign lo_ok    = wb_sel_i[0];
   assign wr_ctrl  = bus_wr && lo_ok && (wb_adr_i == `T16_OFF_CTRL);
   assign wr_force = bus_wr && lo_ok && (wb_adr_i == `T16_OFF_FORCE);
   assign wr_count = bus_wr && lo_ok && (wb_adr_i == `T16_OFF_COUNT);
   assign wr_capt  = bus_wr && lo_ok && (wb_adr_i == `T16_OFF_CAPT);
   assign wr_flags = bus_wr && lo_ok && (wb_adr_i == `T16_OFF_FLAGS);
   assign wr_port  = bus_wr && lo_ok && (wb_adr_i == `T16_OFF_PORT);

   // mode decode; counting is steered by mode select alone
   assign waveform_mode_select =
      ctrl[`T16_CTRL_MODE_MSB:`T16_CTRL_MODE_LSB];
   assign clear_on_match_mode =
      (waveform_mode_select == `T16_MODE_CLR_CMPA) ||
      (waveform_mode_select == `T16_MODE_CLR_CAPT);
   assign non_pwm = clear_on_match_mode ||
                    (waveform_mode_select == `T16_MODE_NORMAL);
   assign top_value = (waveform_mode_select == `T16_MODE_CLR_CAPT)
                      ? capture_reg : compare_reg[0];
   // exact equality only, so a top below the count is passed by
   assign top_hit  = clear_on_match_mode && !match_block &&
                     (counter_value == top_value);
   assign wrap_hit = (counter_value == `T16_CNT_MAX);
   // capture input is off while capture defines top
   assign capt_allowed = (waveform_mode_select != `T16_MODE_CLR_CAPT);
   assign output_action_field[0] =
      ctrl[`T16_CTRL_ACTA_MSB:`T16_CTRL_ACTA_LSB];
   assign output_action_field[1] =
      ctrl[`T16_CTRL_ACTB_MSB:`T16_CTRL_ACTB_LSB];

   // action applied to a latch on a real or forced match
   function automatic logic apply_act(input t16_action_t act,
                                      input logic cur);
      case (act)
         `T16_ACT_TOGGLE: apply_act = !cur;
         `T16_ACT_CLEAR:  apply_act = 1'b0;
         `T16_ACT_SET:    apply_act = 1'b1;
         default:         apply_act = cur;
      endcase
   endfunction : apply_act

   // per channel compare, latch and pin drive
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         assign ch_match[ch] = tick && !match_block &&
                        (counter_value == compare_reg[ch]);
         assign force_compare_strobe[ch] =
            wr_force && wb_dat_i[ch] && non_pwm;

         // latch follows the action in force at the match itself
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               compare_output_latch[ch] <= 1'b0;
            end else if ((ch_match[ch] && non_pwm) ||
                         force_compare_strobe[ch]) begin
               compare_output_latch[ch] <= apply_act(
                  output_action_field[ch],
                  compare_output_latch[ch]);
            end
         end

         // pin source and enable, registered
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               pin_o[ch]  <= 1'b0;
               pin_oe[ch] <= 1'b0;
            end else begin
               pin_o[ch]  <= (output_action_field[ch] != `T16_ACT_NONE)
                             ? compare_output_latch[ch]
                             : port_val[ch];
               pin_oe[ch] <= pin_direction_bit[ch];
            end
         end

         // compare register written straight, unbuffered
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               compare_reg[ch] <= `T16_CNT_ZERO;
            end else if (bus_wr && (wb_adr_i == (`T16_OFF_CMPA +
                         8'(4 * ch)))) begin
               if (wb_sel_i[0]) compare_reg[ch][7:0]  <= wb_dat_i[7:0];
               if (wb_sel_i[1]) compare_reg[ch][15:8] <= wb_dat_i[15:8];
            end
         end
      end
   endgenerate

   // counter: software write first, else count on tick
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         counter_value <= `T16_CNT_ZERO;
      end else if (wr_count) begin
         counter_value <= wb_dat_i[15:0];
      end else if (tick) begin
         if (top_hit) begin
            counter_value <= `T16_CNT_ZERO;
         end else begin
            counter_value <= counter_value + 16'h0001;
         end
      end
   end

   // match blocking after a counter write, held to the next tick
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         match_block <= 1'b0;
      end else if (wr_count) begin
         match_block <= 1'b1;
      end else if (tick) begin
         match_block <= 1'b0;
      end
   end

   // capture register: software write or capture event
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         capture_reg <= `T16_CNT_ZERO;
      end else if (wr_capt) begin
         capture_reg <= wb_dat_i[15:0];
      end else if (capture_event && capt_allowed) begin
         capture_reg <= counter_value;
      end
   end

   // sticky flags; a set in the clearing cycle wins
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flags <= 4'h0;
      end else begin
         flags[`T16_FLAG_OVF] <= (tick && wrap_hit) ||
            (flags[`T16_FLAG_OVF] &&
             !(wr_flags && wb_dat_i[`T16_FLAG_OVF]));
         flags[`T16_FLAG_CMPA] <= ch_match[0] ||
            (flags[`T16_FLAG_CMPA] &&
             !(wr_flags && wb_dat_i[`T16_FLAG_CMPA]));
         flags[`T16_FLAG_CMPB] <= ch_match[1] ||
            (flags[`T16_FLAG_CMPB] &&
             !(wr_flags && wb_dat_i[`T16_FLAG_CMPB]));
         flags[`T16_FLAG_CAPT] <= (tick && top_hit &&
            (waveform_mode_select == `T16_MODE_CLR_CAPT)) ||
            (capture_event && capt_allowed) ||
            (flags[`T16_FLAG_CAPT] &&
             !(wr_flags && wb_dat_i[`T16_FLAG_CAPT]));
      end
   end

   // control and port registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl              <= `T16_CTRL_RESET;
         port_val          <= '0;
         pin_direction_bit <= '0;
      end else begin
         if (wr_ctrl) begin
            ctrl <= wb_dat_i[10:0];
         end
         if (wr_port) begin
            port_val <= wb_dat_i[`T16_PORT_VAL_LSB +: NUM_CH];
            pin_direction_bit <= wb_dat_i[`T16_PORT_DIR_LSB +: NUM_CH];
         end
      end
   end

   // read data mux; unmapped and force read as zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (wb_adr_i)
         `T16_OFF_CTRL:  next_rdata[10:0] = ctrl;
         `T16_OFF_COUNT: next_rdata[15:0] = counter_value;
         `T16_OFF_CMPA:  next_rdata[15:0] = compare_reg[0];
         `T16_OFF_CMPB:  next_rdata[15:0] = compare_reg[1];
         `T16_OFF_CAPT:  next_rdata[15:0] = capture_reg;
         `T16_OFF_FLAGS: next_rdata[3:0]  = flags;
         `T16_OFF_PORT: begin
            next_rdata[`T16_PORT_VAL_LSB +: NUM_CH] = port_val;
            next_rdata[`T16_PORT_DIR_LSB +: NUM_CH] = pin_direction_bit;
            next_rdata[`T16_PORT_LAT_LSB +: NUM_CH] = compare_output_latch;
         end
         default:        next_rdata = 32'h0000_0000;
      endcase
   end

   // single-cycle acknowledge for every address
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? next_rdata : 32'h0000_0000;
      end
   end
endmodule : t16_timer
`default_nettype wire

// ===== t16_timer_tb.sv
// self-checking bench for the 16-bit timer block
`timescale 1ns/1ns
`default_nettype none
`include "t16_cfg.svh"
module t16_timer_tb
   import t16_pkg::*;
   ;
   logic        clk, sys_rst, cyc, stb, we, cap, ack, p;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] dat, dat_o, q;
   logic [15:0] c1, c2, d;
   logic [1:0]  pin_o, pin_oe;
   int          err_count, cmp_count, i;
   logic [1:0]  acts [5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0};
   logic [1:0]  lats [5] = '{2'h3, 2'h0, 2'h3, 2'h0, 2'h0};
   int          dv [4] = '{8, 64, 256, 1024};
   t16_timer #(.NUM_CH(2)) dut (
      .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .capture_event(cap),
      .pin_o(pin_o), .pin_oe(pin_oe));
   // clock, 8 ns period
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task results;
      if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : results
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         err_count++;
      end
   endtask : chk
   // one classic cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] dd);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= dd;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) begin
         err_count++;
         results();
      end
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : wb
   task wr(input logic [7:0] a, input logic [31:0] dd);
      wb(1'b1, a, dd);
   endtask : wr
   task rc(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(q, e);
   endtask : rc
   task rd2;
      wb(1'b0, `T16_OFF_COUNT, 32'h0);
      c1 = q[15:0];
      wb(1'b0, `T16_OFF_COUNT, 32'h0);
      c2 = q[15:0];
      d = c2 - c1;
   endtask : rd2
   function automatic logic [31:0] cw(input logic [2:0] cs,
      input logic [1:0] b, input logic [1:0] a, input logic [3:0] m);
      return {21'h0, cs, b, a, m};
   endfunction : cw
   // watchdog
   initial begin
      repeat (30000) @(posedge clk);
      err_count++;
      results();
   end
   // main sequence
   initial begin
      {cyc, stb, we, cap, adr, dat} = '0;
      sel = 4'hF;
      sys_rst = 1'b1;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rc(`T16_OFF_CTRL, 32'h0);
      rc(`T16_OFF_PORT, 32'h0);
      rc(8'h20, 32'h0);
      rc(`T16_OFF_FORCE, 32'h0);
      wr(`T16_OFF_COUNT, 32'h1234);
      wr(`T16_OFF_PORT, 32'hC);
      for (i = 0; i < 5; i++) begin
         wr(`T16_OFF_CTRL, cw(3'h0, acts[i], acts[i], `T16_MODE_NORMAL));
         wr(`T16_OFF_FORCE, 32'h3);
         rc(`T16_OFF_PORT, {26'h0, lats[i], 4'hC});
      end
      rc(`T16_OFF_FLAGS, 32'h0);
      rc(`T16_OFF_COUNT, 32'h1234);
      wr(`T16_OFF_CTRL, cw(3'h0, 2'h3, 2'h3, `T16_MODE_NORMAL));
      wr(`T16_OFF_FORCE, 32'h1);
      wr(`T16_OFF_PORT, 32'h6);
      #1;
      chk(pin_oe, 32'h1);
      chk(pin_o, 32'h1);
      @(posedge clk);
      wr(`T16_OFF_CTRL, cw(3'h0, 2'h3, 2'h2, `T16_MODE_NORMAL));
      wr(`T16_OFF_COUNT, 32'h0ABC);
      cap <= 1'b1;
      @(posedge clk);
      cap <= 1'b0;
      @(posedge clk);
      rc(`T16_OFF_CAPT, 32'h0ABC);
      rc(`T16_OFF_FLAGS, 32'h8);
      wr(`T16_OFF_CMPA, 32'h10);
      wr(`T16_OFF_CMPB, 32'h11);
      wr(`T16_OFF_COUNT, 32'h10);
      wr(`T16_OFF_FLAGS, 32'hF);
      wr(`T16_OFF_CTRL, cw(3'h1, 2'h0, 2'h0, `T16_MODE_NORMAL));
      rc(`T16_OFF_FLAGS, 32'h4);
      rc(`T16_OFF_PORT, 32'h16);
      chk(pin_o, 32'h2);
      wr(`T16_OFF_CTRL, 32'h0);
      wr(`T16_OFF_FLAGS, 32'hF);
      wr(`T16_OFF_COUNT, 32'hFFFE);
      wr(`T16_OFF_CTRL, cw(3'h1, 2'h0, 2'h0, `T16_MODE_NORMAL));
      rd2();
      chk(d, 32'h3);
      rc(`T16_OFF_FLAGS, 32'h1);
      for (i = 0; i < 4; i++) begin
         wr(`T16_OFF_CTRL, cw(3'(i + 2), 2'h0, 2'h0, `T16_MODE_NORMAL));
         wb(1'b0, `T16_OFF_COUNT, 32'h0);
         c1 = q[15:0];
         repeat (dv[i]) wb(1'b0, `T16_OFF_COUNT, 32'h0);
         d = q[15:0] - c1;
         chk(d, 32'h3);
      end
      wr(`T16_OFF_CTRL, 32'h0);
      wr(`T16_OFF_COUNT, 32'h100);
      wr(`T16_OFF_CTRL, cw(3'h1, 2'h0, 2'h0, `T16_MODE_CLR_CMPA));
      rd2();
      chk(d, 32'h3);
      wr(`T16_OFF_CTRL, 32'h0);
      wr(`T16_OFF_COUNT, 32'h0);
      wr(`T16_OFF_CMPA, 32'h7);
      wr(`T16_OFF_FLAGS, 32'hF);
      wr(`T16_OFF_PORT, 32'h4);
      wr(`T16_OFF_CTRL, cw(3'h1, 2'h0, 2'h1, `T16_MODE_CLR_CMPA));
      #1;
      p = pin_o[0];
      repeat (3) begin
         repeat (8) @(posedge clk);
         #1;
         chk(pin_o[0], {31'h0, ~p});
         p = pin_o[0];
      end
      @(posedge clk);
      rd2();
      chk(c2, (c1 + 16'h3) & 16'h7);
      rc(`T16_OFF_FLAGS, 32'h2);
      wr(`T16_OFF_CTRL, 32'h0);
      wr(`T16_OFF_CMPA, 32'h10);
      wr(`T16_OFF_COUNT, 32'h0);
      wr(`T16_OFF_CAPT, 32'h7);
      wr(`T16_OFF_FLAGS, 32'hF);
      wr(`T16_OFF_CTRL, cw(3'h1, 2'h0, 2'h0, `T16_MODE_CLR_CAPT));
      rd2();
      chk(c2, (c1 + 16'h3) & 16'h7);
      rc(`T16_OFF_FLAGS, 32'h8);
      // capture input ignored while capture defines top
      cap <= 1'b1;
      @(posedge clk);
      cap <= 1'b0;
      @(posedge clk);
      rc(`T16_OFF_CAPT, 32'h7);
      // set both latches, then reset in mid-run
      wr(`T16_OFF_CTRL, cw(3'h0, 2'h3, 2'h3, `T16_MODE_NORMAL));
      wr(`T16_OFF_FORCE, 32'h3);
      rc(`T16_OFF_PORT, 32'h34);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      chk(pin_o, 32'h0);
      chk(pin_oe, 32'h0);
      rc(`T16_OFF_PORT, 32'h0);
      results();
   end
endmodule : t16_timer_tb
bind t16_timer t16_chk #(.NUM_CH(NUM_CH)) u_chk (
   .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .capture_event(capture_event), .pin_o(pin_o), .pin_oe(pin_oe));
`default_nettype wire
